// File: src/uart_interrupt_level_mask_status.sv
// interrupt level, mask and status logic of the serial port
`default_nettype none
module uart_interrupt_level_mask_status
  import irq_ctl_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire apb_req_t          apb_req,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire line_evt_t         line_evt,
  input  wire logic [FILL_W-1:0] rx_fill,
  input  wire logic [FILL_W-1:0] tx_fill,
  input  wire logic              rx_push,
  input  wire logic              sixteen_x_baud_tick,
  input  wire logic              frame_busy,
  output logic                   plain_active,
  output logic                   infrared_active,
  output logic                   combined_irq_out
);

  logic [1:0]        ctrl_q;
  logic [LVL_W-1:0]  level_q;
  logic [NSRC-1:0]   mask_q;
  logic [NSRC-1:0]   raw_q;
  logic [NSRC-1:0]   masked_q;
  logic [NSRC-1:0]   set_d;
  logic [NSRC-1:0]   clr_d;
  logic [FILL_W-1:0] rx_prev_q;
  logic [FILL_W-1:0] tx_prev_q;
  logic [FILL_W-1:0] rx_thr;
  logic [FILL_W-1:0] tx_thr;
  logic [2:0]        rx_level_code;
  logic [2:0]        tx_level_code;
  logic              rx_up_d;
  logic              tx_down_d;
  logic              to_hit_d;
  logic              clr_wr;
  logic [NSRC-1:0]   masked_d;
  logic [TO_W-1:0]   to_cnt_q;
  logic              active_q;
  logic              setup;
  logic              wr;
  logic [31:0]       rd_d;
  logic              hit_d;

  assign setup = apb_req.sel & ~apb_req.enable;
  assign wr    = setup & apb_req.write;

  function automatic logic [FILL_W-1:0] thr_of(input logic [2:0] code);
    logic [FILL_W-1:0] t;
    t = '0;
    unique case (code)
      3'h0:    t = FILL_W'(DEPTH / 8);
      3'h1:    t = FILL_W'(DEPTH / 4);
      3'h2:    t = FILL_W'(DEPTH / 2);
      3'h3:    t = FILL_W'(DEPTH * 3 / 4);
      default: t = FILL_W'(DEPTH * 7 / 8); // reserved codes act as 7/8
    endcase
    return t;
  endfunction : thr_of

  assign rx_level_code = level_q[RX_LVL_LSB +: 3];
  assign tx_level_code = level_q[TX_LVL_LSB +: 3];
  assign rx_thr        = thr_of(rx_level_code);
  assign tx_thr        = thr_of(tx_level_code);

  // crossing detectors: a fill that merely sits on the level fires nothing
  assign rx_up_d   = rx_prev_q <= rx_thr && rx_fill > rx_thr;
  assign tx_down_d = tx_prev_q >= tx_thr && tx_fill < tx_thr;
  assign to_hit_d  = sixteen_x_baud_tick && rx_fill != '0 && !rx_push
                     && to_cnt_q == TO_W'(TIMEOUT_TICKS - 1);
  assign clr_wr    = wr && apb_req.addr == OFS_CLEAR;
  assign masked_d  = raw_q & mask_q;

  // registers written in the setup phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr && apb_req.addr == OFS_CTRL) begin
      ctrl_q <= apb_req.wdata[1:0];
    end
  end

  // only the two level fields are stored, upper bits are dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= LEVEL_RESET;
    end else if (wr && apb_req.addr == OFS_LEVEL) begin
      level_q <= apb_req.wdata[LVL_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= MASK_RESET;
    end else if (wr && apb_req.addr == OFS_MASK) begin
      mask_q <= apb_req.wdata[NSRC-1:0];
    end
  end

  // disable holds active_q until the frame in flight ends; clearing the IR bit still drops infrared_active at the next edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_q        <= 1'b0;
      plain_active    <= 1'b0;
      infrared_active <= 1'b0;
    end else begin
      active_q        <= ctrl_q[CTRL_EN_BIT] | (active_q & frame_busy);
      plain_active    <= active_q & ~ctrl_q[CTRL_IR_BIT];
      infrared_active <= active_q & ctrl_q[CTRL_IR_BIT];
    end
  end

  // previous fills, so a crossing needs both sides of the level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_prev_q <= '0;
    end else begin
      rx_prev_q <= rx_fill;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_prev_q <= '0;
    end else begin
      tx_prev_q <= tx_fill;
    end
  end

  // timeout counter restarts on every new byte so only idle data trips it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      to_cnt_q <= '0;
    end else if (rx_fill == '0 || rx_push) begin
      to_cnt_q <= '0;
    end else if (sixteen_x_baud_tick && to_cnt_q != TO_W'(TIMEOUT_TICKS)) begin
      to_cnt_q <= to_cnt_q + TO_W'(1);
    end
  end

  always_comb begin
    set_d                 = '0;
    set_d[BIT_OVERRUN]    = line_evt.overrun;
    set_d[BIT_BREAK]      = line_evt.brk;
    set_d[BIT_PARITY]     = line_evt.parity;
    set_d[BIT_FRAMING]    = line_evt.framing;
    set_d[3:0]            = line_evt.modem;
    set_d[BIT_RX_TIMEOUT] = to_hit_d;
    set_d[BIT_RX]         = rx_up_d;
    set_d[BIT_TX]         = tx_down_d;
    clr_d                 = clr_wr ? apb_req.wdata[NSRC-1:0] : '0;
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      raw_q <= RAW_RESET;
    end else begin
      raw_q <= (raw_q & ~clr_d) | set_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      masked_q <= '0;
    end else begin
      masked_q <= masked_d;
    end
  end

  // irq taken from the same product as the masked view, so both agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      combined_irq_out <= 1'b0;
    end else begin
      combined_irq_out <= |masked_d;
    end
  end

  always_comb begin
    rd_d  = '0;
    hit_d = 1'b1;
    unique case (apb_req.addr)
      OFS_CTRL:   rd_d[1:0]      = ctrl_q;
      OFS_LEVEL:  rd_d[LVL_W-1:0] = level_q;
      OFS_MASK:   rd_d[NSRC-1:0] = mask_q;
      OFS_RAW:    rd_d[NSRC-1:0] = raw_q;
      OFS_MASKED: rd_d[NSRC-1:0] = masked_q;
      OFS_CLEAR:  rd_d           = '0;
      default:    hit_d          = 1'b0;
    endcase
  end

  // zero-wait slave: answer registered in setup, presented in access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit_d;
      prdata  <= (setup && !apb_req.write) ? rd_d : '0;
    end
  end

endmodule : uart_interrupt_level_mask_status
`default_nettype wire

// File: src/irq_ctl_pkg.sv
// constants and types for the serial port interrupt control block
`default_nettype none
package irq_ctl_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          FILL_W          = 6;
  localparam int          NSRC            = 11;
  localparam int          FIFO_DEPTH      = 32;
  localparam int          TIMEOUT_TICKS   = 511;
  localparam int          TO_W            = 9;

  localparam logic [7:0]  OFS_CTRL        = 8'h30;
  localparam logic [7:0]  OFS_LEVEL       = 8'h34;
  localparam logic [7:0]  OFS_MASK        = 8'h38;
  localparam logic [7:0]  OFS_RAW         = 8'h3C;
  localparam logic [7:0]  OFS_MASKED      = 8'h40;
  localparam logic [7:0]  OFS_CLEAR       = 8'h44;

  localparam int          CTRL_EN_BIT     = 0;
  localparam int          CTRL_IR_BIT     = 1;
  localparam int          RX_LVL_LSB      = 3;
  localparam int          TX_LVL_LSB      = 0;
  localparam int          LVL_W           = 6;

  localparam int          BIT_OVERRUN     = 10;
  localparam int          BIT_BREAK       = 9;
  localparam int          BIT_PARITY      = 8;
  localparam int          BIT_FRAMING     = 7;
  localparam int          BIT_RX_TIMEOUT  = 6;
  localparam int          BIT_TX          = 5;
  localparam int          BIT_RX          = 4;

  localparam logic [1:0]  CTRL_RESET      = 2'h0;
  localparam logic [5:0]  LEVEL_RESET     = 6'h00;
  localparam logic [10:0] MASK_RESET      = 11'h000;
  localparam logic [10:0] RAW_RESET       = 11'h000;

  // line events from the receive path and modem inputs, one-cycle pulses
  typedef struct packed {
    logic       overrun;
    logic       brk;
    logic       parity;
    logic       framing;
    logic [3:0] modem;
  } line_evt_t;

  typedef struct packed {
    logic               sel;
    logic               enable;
    logic               write;
    logic [ADDR_W-1:0]  addr;
    logic [31:0]        wdata;
  } apb_req_t;
endpackage : irq_ctl_pkg
`default_nettype wire

// File: tb/irq_ctl_checker.sv
// assertion checker for the interrupt control block
`default_nettype none
module irq_ctl_checker
  import irq_ctl_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire apb_req_t    apb_req,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        frame_busy,
  input wire logic        plain_active,
  input wire logic        infrared_active,
  input wire logic        combined_irq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire setup = apb_req.sel && !apb_req.enable;
  wire wr = setup && apb_req.write;
  wire ctl = wr && apb_req.addr == OFS_CTRL;
  // only a clear or a mask write may lower the output
  wire drop = wr && (apb_req.addr == OFS_CLEAR || apb_req.addr == OFS_MASK);
  a_ready_after_setup: assert property (setup |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_error_zero_data: assert property (
    pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
  a_mapped_no_error: assert property (
    setup && apb_req.addr == OFS_MASK |=> !pslverr)
    else $error("error on mapped register");
  a_unmapped_error: assert property (
    setup && apb_req.addr == 8'h00 |=> pslverr)
    else $error("no error on unmapped address");
  a_enable_plain: assert property (
    ctl && apb_req.wdata[1:0] == 2'h1 |-> ##[1:3] plain_active)
    else $error("plain function not started");
  a_enable_infrared: assert property (
    ctl && apb_req.wdata[1:0] == 2'h3 |-> ##[1:3] infrared_active)
    else $error("infrared function not started");
  a_frame_finish: assert property (
    (plain_active && frame_busy)[*3] |=> plain_active || infrared_active)
    else $error("stopped during a frame");
  a_irq_drop_cause: assert property (
    $fell(combined_irq_out) |-> $past(drop, 2))
    else $error("interrupt dropped without clear or mask");
endmodule : irq_ctl_checker
bind uart_interrupt_level_mask_status irq_ctl_checker i_chk (.clk, .rst_n,
  .apb_req, .prdata, .pready, .pslverr, .frame_busy, .plain_active,
  .infrared_active, .combined_irq_out);
`default_nettype wire

// File: tb/tb_uart_interrupt_level_mask_status.sv
// self-checking bench for the interrupt control block
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  miscompares++; $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_uart_interrupt_level_mask_status
  import irq_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, tick = 0, busy = 0, push = 0;
  logic pready, pslverr, plain, ir, irq;
  apb_req_t req = '0;
  line_evt_t evt = '0;
  logic [5:0] rxf = '0, txf = '0;
  logic [5:0] thr [5] = '{6'h04, 6'h08, 6'h10, 6'h18, 6'h1C};
  logic [31:0] prdata, m, c;
  logic [33:0] ex, exq[$];
  int miscompares = 0, num_checks = 0;
  uart_interrupt_level_mask_status i_dut (.clk, .rst_n, .apb_req(req),
    .prdata, .pready, .pslverr, .line_evt(evt), .rx_fill(rxf),
    .tx_fill(txf), .rx_push(push), .sixteen_x_baud_tick(tick),
    .frame_busy(busy), .plain_active(plain), .infrared_active(ir),
    .combined_irq_out(irq));
  initial forever #10 clk = ~clk;
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    int n = 0;
    @(negedge clk);
    exq.push_back({~w, e});
    req <= '{1'b1, 1'b0, w, a, d};
    @(negedge clk);
    req.enable <= 1'b1;
    while (pready !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    req <= '0;
  endtask : acc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d, 33'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    acc(1'b0, a, 32'h0, e);
  endtask : rd
  // pulses kept one cycle apart so each counts once
  task automatic ticks(input int n);
    repeat (n) begin
      @(negedge clk) tick <= 1'b1;
      @(negedge clk) tick <= 1'b0;
    end
  endtask : ticks
  // outputs lag a control write by up to three edges
  task automatic settle();
    repeat (3) @(negedge clk);
  endtask : settle
  always @(posedge clk) if (pready === 1'b1) begin
    if (exq.size() == 0) `CHK("queue", 1'b1, 1'b0)
    else begin
      ex = exq.pop_front();
      `CHK("pslverr", ex[32], pslverr)
      if (ex[33]) `CHK("prdata", ex[31:0], prdata)
    end
  end
  initial begin
    void'($urandom(32011));
    repeat (16) @(negedge clk);
    rst_n <= 1'b1;
    rd(OFS_LEVEL, 33'h0);
    rd(OFS_RAW, 33'h0);
    rd(8'h00, {1'b1, 32'h0});
    m = $urandom;
    wr(OFS_LEVEL, m);
    rd(OFS_LEVEL, {27'h0, m[5:0]});
    wr(OFS_RAW, 32'hFFFFFFFF);
    rd(OFS_RAW, 33'h0);
    repeat (3) begin
      m = $urandom;
      c = $urandom;
      wr(OFS_MASK, m);
      rd(OFS_MASK, {22'h0, m[10:0]});
      @(negedge clk) evt <= '{1'b1, 1'b1, 1'b1, 1'b1, 4'hF};
      @(negedge clk) evt <= '0;
      rd(OFS_RAW, 33'h78F);
      rd(OFS_MASKED, {22'h0, m[10:0] & 11'h78F});
      `CHK("irq", |(m[10:0] & 11'h78F), irq)
      wr(OFS_CLEAR, c);
      rd(OFS_RAW, {22'h0, 11'h78F & ~c[10:0]});
      wr(OFS_CLEAR, 32'h7FF);
    end
    for (int k = 0; k < 5; k++) begin
      wr(OFS_LEVEL, {26'h0, k[2:0], k[2:0]});
      rxf <= thr[k];
      txf <= 6'h20;
      rd(OFS_RAW, 33'h0);
      rxf <= thr[k] + 6'h01;
      txf <= thr[k];
      rd(OFS_RAW, 33'h10);
      txf <= thr[k] - 6'h01;
      rd(OFS_RAW, 33'h30);
      rxf <= '0;
      txf <= '0;
      wr(OFS_CLEAR, 32'h7FF);
    end
    rxf <= 6'h01;
    ticks(300);
    @(negedge clk) push <= 1'b1;
    @(negedge clk) push <= 1'b0;
    ticks(510);
    rd(OFS_RAW, 33'h0);
    ticks(1);
    rd(OFS_RAW, 33'h40);
    rxf <= '0;
    wr(OFS_CTRL, 32'h1);
    settle();
    `CHK("plain", 1'b1, plain)
    busy <= 1'b1;
    wr(OFS_CTRL, 32'h0);
    settle();
    `CHK("plain", 1'b1, plain)
    busy <= 1'b0;
    settle();
    `CHK("plain", 1'b0, plain)
    wr(OFS_CTRL, 32'h3);
    settle();
    `CHK("ir", 1'b1, ir)
    `CHK("plain", 1'b0, plain)
    results();
  end
  initial begin
    #200000;
    miscompares++;
    results();
  end
  task automatic results();
    if (miscompares == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
endmodule : tb_uart_interrupt_level_mask_status
`default_nettype wire
